// ---- common/prog_pkg.sv ----
// Purpose : Constants and types for the one-time-programmable memory programmer
// Assumes : 100 MHz clock
// Notes   : Times in ns, counts derived from the clock period
package prog_pkg;
   localparam int          CLK_PERIOD_NS    = 10;
   localparam int          ADDR_W           = 18;
   localparam int          DATA_W           = 8;
   localparam int          PULSE_NS         = 100000;
   localparam int          PULSE_CYC        = PULSE_NS / CLK_PERIOD_NS;
   localparam int          SETUP_NS         = 2000;
   localparam int          SETUP_CYC        = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          MAX_PULSES       = 10;
   localparam int          CNT_W            = 24;
   localparam logic [ADDR_W-1:0] ADDR_FIRST = 18'h00000;
   localparam logic [ADDR_W-1:0] ADDR_LAST  = 18'h3FFFF;
   localparam logic [3:0]  PULSE_ZERO       = 4'h0;

   typedef enum logic [1:0] {
      SUP_NORMAL,
      SUP_PROGRAM,
      SUP_IDENT
   } supply_t;

   typedef enum logic [1:0] {
      RES_NONE,
      RES_PASS,
      RES_FAIL
   } result_t;
endpackage

// ---- src/otp_prog_ctrl.sv ----
// Purpose : Programmer that burns, verifies and checks an OTP byte memory
// Assumes : Source bytes arrive in address order, once per pass
// Notes   : Supplies are requested through supply_sel; levels are outside
//
// Function
// - Strobe pulse 100 us, within 95..105 us
// - Start with address at first location
// - Raise supplies to programming levels first
// - First pass: one pulse per address
// - Verify loop, re-pulse up to ten times
// - Ten failed re-pulses: stop, device failed
// - Verified byte advances to next address
// - After verify, lower supplies to normal
// - Final read at normal supply, pass/fail
// - Identification: other lines low, line nine high-voltage
`timescale 1ns/1ps
module otp_prog_ctrl
   import prog_pkg::*;
#(
   parameter int PULSE_CYCLES = PULSE_CYC,
   parameter int SETUP_CYCLES = SETUP_CYC,
   parameter int LAST_ADDR    = ADDR_LAST
) (
   input  wire logic              clock,
   input  wire logic              rst_b,
   input  wire logic              start,
   input  wire logic              id_start,
   input  wire logic              src_valid,
   output logic                   src_ready,
   input  wire logic [DATA_W-1:0] src_data,
   output logic                   src_rewind,
   output logic [ADDR_W-1:0]      addr,
   output logic                   id_byte_select_bit,
   output logic                   id_mode_address_line,
   output logic [DATA_W-1:0]      data_out,
   output logic                   data_oe,
   input  wire logic [DATA_W-1:0] data_outputs,
   output logic                   chip_enable_n,
   output logic                   output_enable_n,
   output logic                   program_strobe_n,
   output supply_t                supply_sel,
   output logic                   busy,
   output result_t                result,
   output logic [DATA_W-1:0]      mfr_code,
   output logic [DATA_W-1:0]      dev_code,
   output logic                   id_done
);
   typedef enum logic [3:0] {
      S_IDLE, S_RAMP, S_LOAD, S_PULSE, S_VERIFY, S_CHECK,
      S_DROP, S_READ, S_IDREAD, S_DONE
   } state_t;
   typedef enum logic [1:0] { P_BURN, P_VERIFY, P_FINAL } phase_t;

   // ----------------------------------------
   // Reset and input synchronisers
   // ----------------------------------------
   logic              rst_s1, rst_n_sync;
   logic [DATA_W-1:0] din_s1, din_s2;

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         rst_s1     <= 1'b0;
         rst_n_sync <= 1'b0;
      end else begin
         rst_s1     <= 1'b1;
         rst_n_sync <= rst_s1;
      end
   end

   // Pin data from an unclocked device
   always_ff @(posedge clock or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         din_s1 <= 8'h00;
         din_s2 <= 8'h00;
      end else begin
         din_s1 <= data_outputs;
         din_s2 <= din_s1;
      end
   end

   // ----------------------------------------
   // Source buffer
   // ----------------------------------------
   logic              buf_valid;
   logic              buf_ready;
   logic [DATA_W-1:0] buf_data;

   skid_buf #(.W(DATA_W)) u_buf (
      .clock      (clock),
      .rst_n_sync (rst_n_sync),
      .in_valid   (src_valid),
      .in_ready   (src_ready),
      .in_data    (src_data),
      .out_valid  (buf_valid),
      .out_ready  (buf_ready),
      .out_data   (buf_data)
   );

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   state_t            st_r;
   phase_t            ph_r;
   logic [CNT_W-1:0]  tmr_r;
   logic [3:0]        npulse_r;
   logic [DATA_W-1:0] byte_r;
   logic              fail_r;
   logic              last_addr;
   logic              tmr_zero;

   assign last_addr = (addr == LAST_ADDR[ADDR_W-1:0]);
   assign tmr_zero  = (tmr_r == '0);
   assign buf_ready = (st_r == S_LOAD) || (st_r == S_READ && tmr_zero);
   assign busy      = (st_r != S_IDLE) && (st_r != S_DONE);

   function automatic logic [CNT_W-1:0] cyc(input int n);
      cyc = n[CNT_W-1:0] - 1'b1;
   endfunction

   always_ff @(posedge clock or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         st_r       <= S_IDLE;
         ph_r       <= P_BURN;
         tmr_r      <= '0;
         npulse_r   <= PULSE_ZERO;
         byte_r     <= 8'h00;
         fail_r     <= 1'b0;
         addr       <= ADDR_FIRST;
         supply_sel <= SUP_NORMAL;
         result     <= RES_NONE;
         src_rewind <= 1'b0;
         mfr_code   <= 8'h00;
         dev_code   <= 8'h00;
         id_done    <= 1'b0;
      end else begin
         src_rewind <= 1'b0;
         id_done    <= 1'b0;
         if (!tmr_zero) begin
            tmr_r <= tmr_r - 1'b1;
         end
         case (st_r)
            S_IDLE, S_DONE: begin
               if (start) begin
                  addr       <= ADDR_FIRST;
                  supply_sel <= SUP_PROGRAM;
                  ph_r       <= P_BURN;
                  fail_r     <= 1'b0;
                  result     <= RES_NONE;
                  tmr_r      <= cyc(SETUP_CYCLES);
                  st_r       <= S_RAMP;
               end else if (id_start) begin
                  addr       <= ADDR_FIRST;
                  supply_sel <= SUP_IDENT;
                  tmr_r      <= cyc(SETUP_CYCLES);
                  st_r       <= S_IDREAD;
               end
            end
            S_RAMP: begin
               if (tmr_zero) begin
                  st_r <= S_LOAD;
               end
            end
            S_LOAD: begin
               if (buf_valid) begin
                  byte_r   <= buf_data;
                  npulse_r <= PULSE_ZERO;
                  tmr_r    <= cyc(SETUP_CYCLES);
                  st_r     <= (ph_r == P_BURN) ? S_PULSE : S_VERIFY;
               end
            end
            S_PULSE: begin
               // Setup time counted first, then the 100 us pulse
               if (tmr_zero) begin
                  if (program_strobe_n) begin
                     tmr_r <= cyc(PULSE_CYCLES);
                  end else begin
                     tmr_r    <= cyc(SETUP_CYCLES);
                     npulse_r <= (ph_r == P_BURN) ? npulse_r : npulse_r + 4'h1;
                     if (ph_r == P_BURN) begin
                        if (last_addr) begin
                           addr       <= ADDR_FIRST;
                           ph_r       <= P_VERIFY;
                           src_rewind <= 1'b1;
                        end else begin
                           addr <= addr + 1'b1;
                        end
                        st_r <= S_LOAD;
                     end else begin
                        st_r <= S_VERIFY;
                     end
                  end
               end
            end
            S_VERIFY: begin
               // Setup count alone before compare; the two sync stages fall inside it
               if (tmr_zero) begin
                  st_r <= S_CHECK;
               end
            end
            S_CHECK: begin
               tmr_r <= cyc(SETUP_CYCLES);
               if (din_s2 == byte_r) begin
                  if (last_addr) begin
                     addr       <= ADDR_FIRST;
                     supply_sel <= SUP_NORMAL;
                     ph_r       <= P_FINAL;
                     src_rewind <= 1'b1;
                     st_r       <= S_DROP;
                  end else begin
                     addr <= addr + 1'b1;
                     st_r <= S_LOAD;
                  end
               end else if (npulse_r == MAX_PULSES[3:0]) begin
                  supply_sel <= SUP_NORMAL;
                  result     <= RES_FAIL;
                  st_r       <= S_DONE;
               end else begin
                  st_r <= S_PULSE;
               end
            end
            S_DROP: begin
               // Fresh setup count, else the first read compares stale pins
               if (tmr_zero) begin
                  tmr_r <= cyc(SETUP_CYCLES);
                  st_r  <= S_READ;
               end
            end
            S_READ: begin
               // Source byte popped from the buffer at the compare
               if (tmr_zero && buf_valid) begin
                  if (din_s2 != buf_data) begin
                     fail_r <= 1'b1;
                  end
                  tmr_r <= cyc(SETUP_CYCLES);
                  if (last_addr) begin
                     result <= (fail_r || din_s2 != buf_data) ? RES_FAIL : RES_PASS;
                     st_r   <= S_DONE;
                  end else begin
                     addr <= addr + 1'b1;
                  end
               end
            end
            S_IDREAD: begin
               if (tmr_zero) begin
                  if (addr[0]) begin
                     dev_code   <= din_s2;
                     supply_sel <= SUP_NORMAL;
                     id_done    <= 1'b1;
                     addr       <= ADDR_FIRST;
                     st_r       <= S_DONE;
                  end else begin
                     mfr_code <= din_s2;
                     addr     <= addr + 1'b1;
                     tmr_r    <= cyc(SETUP_CYCLES);
                  end
               end
            end
            default: begin
               st_r <= S_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------
   // Pin drive
   // ----------------------------------------
   logic pulse_on;
   logic read_on;
   logic pin_prog;

   assign pulse_on = (st_r == S_PULSE) && (program_strobe_n == 1'b0 || tmr_zero);
   assign read_on  = (st_r == S_VERIFY) || (st_r == S_CHECK) ||
                     (st_r == S_READ) || (st_r == S_IDREAD);
   assign pin_prog = (st_r == S_PULSE);

   // Strobe registered so its width is exactly the counted time
   always_ff @(posedge clock or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         program_strobe_n <= 1'b1;
         chip_enable_n    <= 1'b1;
         output_enable_n  <= 1'b1;
         data_oe          <= 1'b0;
         data_out         <= 8'h00;
      end else begin
         program_strobe_n <= !(pulse_on && !(program_strobe_n == 1'b0 && tmr_zero));
         chip_enable_n    <= !(pin_prog || read_on);
         output_enable_n  <= !read_on;
         data_oe          <= pin_prog;
         data_out         <= byte_r;
      end
   end

   assign id_byte_select_bit   = addr[0];
   assign id_mode_address_line = (st_r == S_IDREAD);
endmodule

// ---- src/skid_buf.sv ----
// Purpose : Two-entry valid/ready buffer
// Assumes : Single clock, active-low synchronous-released reset
// Notes   : Stall on the drain side holds both words
`timescale 1ns/1ps
module skid_buf #(
   parameter int W = 8
) (
   input  wire logic         clock,
   input  wire logic         rst_n_sync,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   logic [W-1:0] mem_r [2];
   logic         wp_r;
   logic         rp_r;
   logic [1:0]   cnt_r;
   logic         push;
   logic         pop;

   assign in_ready  = (cnt_r != 2'h2);
   assign out_valid = (cnt_r != 2'h0);
   assign out_data  = mem_r[rp_r];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_ff @(posedge clock) begin
      if (push) begin
         mem_r[wp_r] <= in_data;
      end
   end

   always_ff @(posedge clock or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         wp_r  <= 1'b0;
         rp_r  <= 1'b0;
         cnt_r <= 2'h0;
      end else begin
         if (push) begin
            wp_r <= ~wp_r;
         end
         if (pop) begin
            rp_r <= ~rp_r;
         end
         cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
      end
   end
endmodule

// ---- tb/otp_mem_model.sv ----
// Purpose : Behavioural one-time-programmable byte memory
// Assumes : One chosen address needs stub_need pulses to take its data
// Notes   : Released bus shows the inverse of the last byte read
`timescale 1ns/1ps
module otp_mem_model
   import prog_pkg::*;
#(
   parameter int         LAST = 3,
   parameter logic [7:0] MFR  = 8'hA5, // Arbitrary value
   parameter logic [7:0] DEV  = 8'h3C  // Arbitrary value
) (
   input  wire logic              clock,
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic              id_byte_select_bit,
   input  wire logic              id_mode_address_line,
   input  wire logic [7:0]        data_out,
   input  wire logic              data_oe,
   input  wire logic              chip_enable_n,
   input  wire logic              output_enable_n,
   input  wire logic              program_strobe_n,
   input  wire supply_t           supply_sel,
   input  wire logic [ADDR_W-1:0] stub_addr,
   input  wire logic [7:0]        stub_need,
   output logic [7:0]             data_outputs
);
   logic [7:0] mem [0:LAST];
   int         hits [0:LAST];
   logic [7:0] rd;
   logic [7:0] last_q = 8'h00;
   logic       drive;
   task erase();
      foreach (mem[i]) begin
         mem[i]  = 8'hFF;
         hits[i] = 0;
      end
   endtask
   // Cells only clear bits, so a pulse can never restore a one
   always @(negedge program_strobe_n) begin
      if (!chip_enable_n && output_enable_n && data_oe &&
          supply_sel == SUP_PROGRAM) begin
         hits[addr] = hits[addr] + 1;
         if (addr != stub_addr || hits[addr] >= stub_need) mem[addr] = mem[addr] & data_out;
      end
   end
   assign drive = !chip_enable_n && !output_enable_n && program_strobe_n;
   assign rd = (id_mode_address_line && addr[ADDR_W-1:1] == '0) ?
               (id_byte_select_bit ? DEV : MFR) : mem[addr];
   assign data_outputs = drive ? rd : ~last_q;
   always @(posedge clock) if (drive) last_q <= rd;
endmodule

// ---- tb/otp_prog_checker.sv ----
// Purpose : Concurrent checks on the programmer's memory-side pins
// Assumes : Pulse length given by PULSE_CYCLES
// Notes   : Bound into otp_prog_ctrl
`timescale 1ns/1ps
module otp_prog_checker
   import prog_pkg::*;
#(
   parameter int PULSE_CYCLES = PULSE_CYC
) (
   input wire logic              clock,
   input wire logic              rst_b,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic              id_mode_address_line,
   input wire logic [DATA_W-1:0] data_out,
   input wire logic              data_oe,
   input wire logic              chip_enable_n,
   input wire logic              output_enable_n,
   input wire logic              program_strobe_n,
   input wire supply_t           supply_sel,
   input wire result_t           result
);
   int                lo_cnt;
   int                pulse_cnt;
   logic [ADDR_W-1:0] addr_q;
   logic              strobe_q;
   // ---------------------------------------------
   // Helper counters
   // ---------------------------------------------
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) lo_cnt <= 0;
      else lo_cnt <= program_strobe_n ? 0 : lo_cnt + 1;
   end
   // Pulses at the present address; a new address restarts the count
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         pulse_cnt <= 0;
         addr_q    <= ADDR_FIRST;
         strobe_q  <= 1'b1;
      end else begin
         addr_q    <= addr;
         strobe_q  <= program_strobe_n;
         pulse_cnt <= (addr != addr_q) ? 0 : pulse_cnt + int'(strobe_q && !program_strobe_n);
      end
   end
   // ---------------------------------------------
   // Properties
   // ---------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);
   sequence s_held;
      !program_strobe_n ##1 !program_strobe_n;
   endsequence
   sequence s_pgm_up;
      $changed(supply_sel) ##0 supply_sel == SUP_PROGRAM;
   endsequence
   property p_width;
      $rose(program_strobe_n) |->
         lo_cnt >= PULSE_CYCLES * 95 / 100 && lo_cnt <= PULSE_CYCLES * 105 / 100;
   endproperty
   property p_pgm_pins;
      !program_strobe_n |-> !chip_enable_n && output_enable_n && data_oe;
   endproperty
   property p_vfy_pins;
      !output_enable_n |-> program_strobe_n && !data_oe;
   endproperty
   property p_pulse_stable;
      s_held |-> $stable(addr) && $stable(data_out);
   endproperty
   property p_pgm_supply;
      !program_strobe_n |-> supply_sel == SUP_PROGRAM;
   endproperty
   property p_first_addr;
      s_pgm_up |-> addr == ADDR_FIRST;
   endproperty
   property p_retry_cap;
      pulse_cnt <= MAX_PULSES;
   endproperty
   property p_id_lines;
      id_mode_address_line |-> addr[ADDR_W-1:1] == '0 && program_strobe_n;
   endproperty
   property p_end_supply;
      $changed(result) && result != RES_NONE |-> supply_sel == SUP_NORMAL;
   endproperty
   a_width: assert property (p_width) else $error("strobe width out of range");
   a_pgm_pins: assert property (p_pgm_pins) else $error("bad pins in pulse");
   a_vfy_pins: assert property (p_vfy_pins) else $error("bad pins in verify");
   a_pulse_stable: assert property (p_pulse_stable) else $error("moved in pulse");
   a_pgm_supply: assert property (p_pgm_supply) else $error("pulse off supply");
   a_first_addr: assert property (p_first_addr) else $error("not first address");
   a_retry_cap: assert property (p_retry_cap) else $error("too many pulses");
   a_id_lines: assert property (p_id_lines) else $error("bad id address");
   a_end_supply: assert property (p_end_supply) else $error("supply not normal");
endmodule
bind otp_prog_ctrl otp_prog_checker #(.PULSE_CYCLES(PULSE_CYCLES)) chk (.clock, .rst_b,
   .addr, .id_mode_address_line, .data_out, .data_oe, .chip_enable_n, .output_enable_n,
   .program_strobe_n, .supply_sel, .result);

// ---- tb/otp_prog_ctrl_tb.sv ----
// Purpose : Self-checking bench for otp_prog_ctrl against a memory model
// Assumes : Short pulse and setup counts, four addresses
// Notes   : Failing device run goes last, it leaves the source mid-pass
`timescale 1ns/1ps
module otp_prog_ctrl_tb;
   import prog_pkg::*;
   localparam int         LAST  = 3;
   localparam logic [7:0] MFR_C = 8'hA5; // Arbitrary value
   localparam logic [7:0] DEV_C = 8'h3C; // Arbitrary value
   logic clock = 0, rst_b = 0, start = 0, id_start = 0, src_valid = 0, src_ready, src_rewind;
   logic id_mode_address_line, data_oe, chip_enable_n, output_enable_n, program_strobe_n;
   logic busy, id_done, hs, rw, strobe_q, v, id_byte_select_bit;
   logic [7:0]        src_data = 8'h00, data_out, data_outputs, mfr_code, dev_code, stub_need;
   logic [7:0]        data [0:LAST];
   logic [ADDR_W-1:0] addr, stub_addr = '0;
   supply_t           supply_sel;
   result_t           result;
   logic [31:0]       seed = 32'hE1B83993;
   int                error_cnt = 0, samples_checked = 0, idx = 0, n, sc, need, pulses [0:LAST];
   otp_prog_ctrl #(.PULSE_CYCLES(20), .SETUP_CYCLES(4), .LAST_ADDR(LAST)) DUT (.clock, .rst_b,
      .start, .id_start, .src_valid, .src_ready, .src_data, .src_rewind, .addr,
      .id_byte_select_bit, .id_mode_address_line, .data_out, .data_oe, .data_outputs,
      .chip_enable_n, .output_enable_n, .program_strobe_n, .supply_sel, .busy, .result,
      .mfr_code, .dev_code, .id_done);
   otp_mem_model #(.LAST(LAST), .MFR(MFR_C), .DEV(DEV_C)) far (.clock, .addr,
      .id_byte_select_bit,
      .id_mode_address_line, .data_out, .data_oe, .chip_enable_n, .output_enable_n,
      .program_strobe_n, .supply_sel, .stub_addr, .stub_need, .data_outputs);
   initial forever #5 clock = ~clock;
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic result_t exp_res(int nd);
      return nd <= MAX_PULSES + 1 ? RES_PASS : RES_FAIL;
   endfunction
   function automatic int exp_pulses(int a, int st, int nd);
      return a == st ? (nd < MAX_PULSES + 1 ? nd : MAX_PULSES + 1) : 1;
   endfunction
   task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task wrap_up();
      $display("checks %0d errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task tick();
      @(posedge clock);
      #1;
   endtask
   task kick(input bit id);
      if (id) id_start = 1;
      else start = 1;
      tick();
      start    = 0;
      id_start = 0;
   endtask
   // ---------------------------------------------
   // Source stream, random stalls, held until taken
   // ---------------------------------------------
   always @(negedge clock) begin
      hs = src_valid && src_ready;
      rw = src_rewind;
      if (strobe_q && !program_strobe_n) pulses[addr[1:0]]++;
      strobe_q = program_strobe_n;
   end
   always @(posedge clock) begin
      #1;
      v = src_valid && !hs && !rw;
      if (rw) idx = 0;
      else if (hs) idx++;
      if (!v && idx <= LAST && rnd() % 4 != 0) v = 1;
      src_valid = v;
      src_data  = v ? data[idx] : ~src_data;
   end
   // ---------------------------------------------
   // Scenarios
   // ---------------------------------------------
   initial begin
      #600000;
      error_cnt++;
      wrap_up();
   end
   initial begin
      repeat (3) @(posedge clock);
      #1 rst_b = 1;
      repeat (3) tick();
      for (sc = 0; sc < 3; sc++) begin
         if (sc == 2) begin
            kick(1'b1);
            for (n = 0; n < 2000 && id_done !== 1'b1; n++) tick();
            check("mfr", mfr_code, MFR_C);
            check("dev", dev_code, DEV_C);
         end
         need      = sc == 0 ? 4 : (sc == 1 ? 11 : 12);
         stub_need = need[7:0];
         stub_addr = ADDR_W'(rnd() % (LAST + 1));
         foreach (data[i]) data[i] = 8'(rnd());
         data[0] = sc == 1 ? 8'h00 : data[0];
         data[stub_addr[1:0]] = data[stub_addr[1:0]] & 8'h7F;
         far.erase();
         pulses = '{default: 0};
         idx    = 0;
         kick(1'b0);
         for (n = 0; n < 100 && busy !== 1'b1; n++) tick();
         repeat (40) tick();
         kick(1'b0);
         for (n = 0; n < 40000 && busy !== 1'b0; n++) tick();
         check("result", result, exp_res(need));
         check("supply", supply_sel, SUP_NORMAL);
         for (int a = 0; a <= LAST; a++) begin
            check("pulses", pulses[a], exp_pulses(a, stub_addr, need));
            if (sc < 2) check("cell", far.mem[a], data[a]);
         end
      end
      wrap_up();
   end
endmodule
